// ==== sim/dplim_regs_asserts.sv ====
// concurrent checks on the pull-in limit and irq-enable register ports
`timescale 1ns/1ps
`default_nettype none
module dplim_regs_asserts #(
    parameter int OFS_W = 24                                    // loop offset width
) (
    input wire logic                                clk,        // system clock
    input wire logic                                reset,      // sync, active high
    input wire logic                                reg_wr,     // write strobe
    input wire logic                                reg_rd,     // read strobe
    input wire logic [dplim_pkg::ADDR_W-1:0]        reg_addr,   // offset
    input wire logic [dplim_pkg::DATA_W-1:0]        reg_wdata,  // write byte
    input wire logic                                reg_rvalid, // read answer
    input wire logic [dplim_pkg::NUM_REFS-1:0]      ref_event,  // events in
    input wire logic [dplim_pkg::NUM_REFS-1:0]      ref_irq,    // gated events
    input wire logic signed [OFS_W-1:0]             main_ofs_out, // clamped offset
    input wire logic                                main_clipped, // at limit
    input wire logic [dplim_pkg::LIMIT_W-1:0]       pull_in_limit_value // joined limit
);
    logic [2:0]         en_r;   // shadow of enables three, two, one
    logic signed [10:0] lim_s;  // limit as a signed magnitude
    assign lim_s = $signed({1'b0, pull_in_limit_value});
    // shadow kept here so mask checks need no probe into the body
    always_ff @(posedge clk) begin
        if (reset) begin
            en_r <= 3'h0;
        end else if (reg_wr && reg_addr == 8'h43) begin
            en_r <= {reg_wdata[7], reg_wdata[3], reg_wdata[2]};
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_rst_defaults: assert property ($fell(reset) |->
        pull_in_limit_value == 10'h076 && ref_irq == 3'h0) else $error("bad reset value");
    a_rd_answer: assert property (reg_rd |=> reg_rvalid) else $error("read unanswered");
    a_rd_quiet: assert property (!reg_rd |=> !reg_rvalid) else $error("stray read answer");
    a_wr_low: assert property (reg_wr && reg_addr == 8'h41 |=>
        pull_in_limit_value[7:0] == $past(reg_wdata)) else $error("low limit byte wrong");
    a_wr_high: assert property (reg_wr && reg_addr == 8'h42 |=>
        pull_in_limit_value[9:8] == $past(reg_wdata[1:0])) else $error("high limit wrong");
    a_irq_one: assert property (ref_irq[0] == $past(ref_event[0] & en_r[0]))
        else $error("input one gating wrong");
    a_irq_two: assert property (ref_irq[1] == $past(ref_event[1] & en_r[1]))
        else $error("input two gating wrong");
    a_irq_three: assert property (ref_irq[2] == $past(ref_event[2] & en_r[2]))
        else $error("input three gating wrong");
    a_clamp_range: assert property ($stable(pull_in_limit_value) |->
        main_ofs_out <= lim_s && main_ofs_out >= -lim_s) else $error("offset past limit");
    a_clip_value: assert property (main_clipped |->
        main_ofs_out == $past(lim_s) || main_ofs_out == -$past(lim_s)) else $error("clip bad");
endmodule // dplim_regs_asserts
bind dplim_regs dplim_regs_asserts #(.OFS_W(OFS_W)) u_chk (.clk, .reset, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rvalid, .ref_event, .ref_irq, .main_ofs_out, .main_clipped,
    .pull_in_limit_value);
`default_nettype wire

// ==== sim/dplim_regs_bench.sv ====
// self-checking bench for the pull-in limit and irq-enable registers
`timescale 1ns/1ps
`default_nettype none
module dplim_regs_bench;
    logic               clk, reset, reg_wr, reg_rd, reg_rvalid, main_clipped, aux_clipped;
    logic [7:0]         reg_addr, reg_wdata, reg_rdata;
    logic [2:0]         ref_event, ref_irq;
    logic signed [23:0] main_ofs_in, aux_ofs_in, cal_corr, main_ofs_out, aux_ofs_out;
    logic [9:0]         pull_in_limit_value;
    int                 errors, tests_run;
    dplim_regs #(.OFS_W(24)) dut (.clk, .reset, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .reg_rvalid, .ref_event, .ref_irq, .main_ofs_in, .aux_ofs_in, .cal_corr,
        .main_ofs_out, .aux_ofs_out, .main_clipped, .aux_clipped, .pull_in_limit_value);
    // 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input string what, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // one-cycle write strobe, launched off the falling edge
    task automatic wr(input logic [7:0] a, d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    // the answer is registered on the taking edge and checked at the next falling edge
    task automatic rdchk(input logic [7:0] a, exp);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        chk("rvalid", reg_rvalid, 1'b1);
        chk($sformatf("reg %0h", a), reg_rdata, exp);
    endtask
    task automatic ev(input logic [2:0] exp);
        @(negedge clk);
        ref_event = 3'h7;
        @(negedge clk);
        ref_event = 3'h0;
        chk("ref_irq", ref_irq, exp);
    endtask
    task automatic cl(input int mi, ai, c, me, ae, input logic mc, ac);
        @(negedge clk);
        main_ofs_in = 24'(mi);
        aux_ofs_in = 24'(ai);
        cal_corr = 24'(c);
        @(negedge clk);
        chk("main_ofs_out", main_ofs_out, me);
        chk("aux_ofs_out", aux_ofs_out, ae);
        chk("main_clipped", main_clipped, mc);
        chk("aux_clipped", aux_clipped, ac);
    endtask
    task automatic t_reset_vals();
        chk("limit", pull_in_limit_value, 10'h076);
        rdchk(8'h41, 8'h76);
        rdchk(8'h42, 8'h00);
        rdchk(8'h43, 8'h00);
        ev(3'h0);
    endtask
    task automatic t_limit();
        wr(8'h41, 8'hFF);
        wr(8'h42, 8'hFF);
        rdchk(8'h42, 8'h03);
        chk("limit", pull_in_limit_value, 10'h3FF);
        wr(8'h41, 8'h00);
        chk("limit", pull_in_limit_value, 10'h300);
        wr(8'h42, 8'h02);
        chk("limit", pull_in_limit_value, 10'h200);
        wr(8'h40, 8'hFF);
        rdchk(8'h40, 8'h00);
        rdchk(8'h41, 8'h00);
    endtask
    task automatic t_irq();
        int pos[3] = '{2, 3, 7};
        for (int i = 0; i < 3; i++) begin
            wr(8'h43, 8'(1 << pos[i]));
            ev(3'(1 << i));
        end
        wr(8'h43, 8'hFF);
        rdchk(8'h43, 8'h8C);
        ev(3'h7);
        wr(8'h43, 8'h00);
        ev(3'h0);
    endtask
    // limit is 512 here; equal to the limit passes, one past it clips
    task automatic t_clamp();
        cl(1000, -1000, 0, 512, -512, 1'b1, 1'b1);
        cl(513, -512, 0, 512, -512, 1'b1, 1'b0);
        cl(500, -500, 20, 512, -480, 1'b1, 1'b0);
        cl(100, -30, -50, 50, -80, 1'b0, 1'b0);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        reset = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        ref_event = 3'h0;
        main_ofs_in = '0;
        aux_ofs_in = '0;
        cal_corr = '0;
        errors = 0;
        tests_run = 0;
        repeat (20) @(negedge clk);
        reset = 1'b0;
        t_reset_vals();
        t_limit();
        t_irq();
        t_clamp();
        // a second reset mid-run must bring every default back
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        t_reset_vals();
        tally_and_finish();
    end
    // the sequence needs about 84 cycles; give it generous room
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        tally_and_finish();
    end
endmodule // dplim_regs_bench
`default_nettype wire

// ==== verilog/dplim_clamp.sv ====
// symmetric clamp of one loop frequency offset against the pull-in limit
`timescale 1ns/1ps
`default_nettype none
module dplim_clamp #(
    parameter int OFS_W = 24                                  // offset width, two's complement
) (
    input  wire logic                            clk,         // system clock
    input  wire logic                            reset,       // synchronous, active high
    input  wire logic signed [OFS_W-1:0]         ofs_in,      // raw loop offset
    input  wire logic signed [OFS_W-1:0]         cal_corr,    // oscillator calibration term
    input  wire logic [dplim_pkg::LIMIT_W-1:0]   limit,       // unsigned pull-in limit
    output logic signed [OFS_W-1:0]              ofs_out,     // clamped offset (registered)
    output logic                                 clipped      // limit was hit (registered)
);

    typedef struct packed {
        logic [OFS_W-1:0] ofs;
        logic             clipped;
    } dplim_clamp_st_t;

    dplim_clamp_st_t st_r;
    dplim_clamp_st_t st_nxt;

    logic signed [OFS_W:0] sum;
    logic signed [OFS_W:0] lim_pos;
    logic signed [OFS_W:0] lim_neg;

    // the limit must sit well inside the offset range so a truncated sum is never mistaken
    if (OFS_W < dplim_pkg::LIMIT_W + 2) begin : g_bad_width
        $error("dplim_clamp: OFS_W too small for the pull-in limit");
    end

    // calibration is folded in before the bound, so the corrected offset is what is limited
    assign sum     = {ofs_in[OFS_W-1], ofs_in} + {cal_corr[OFS_W-1], cal_corr};
    assign lim_pos = signed'({{(OFS_W+1-dplim_pkg::LIMIT_W){1'b0}}, limit});
    assign lim_neg = -lim_pos;

    // next state: bound the magnitude equally in both directions
    always_comb begin
        st_nxt = st_r;
        if (sum > lim_pos) begin
            st_nxt.ofs     = lim_pos[OFS_W-1:0];
            st_nxt.clipped = 1'b1;
        end else if (sum < lim_neg) begin
            st_nxt.ofs     = lim_neg[OFS_W-1:0];
            st_nxt.clipped = 1'b1;
        end else begin
            st_nxt.ofs     = sum[OFS_W-1:0];
            st_nxt.clipped = 1'b0;
        end
        if (reset) begin
            st_nxt = '0;
        end
    end

    // state register
    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    assign ofs_out = signed'(st_r.ofs);
    assign clipped = st_r.clipped;

endmodule // dplim_clamp
`default_nettype wire

// ==== verilog/dplim_pkg.sv ====
// constants shared by the pull-in limit and interrupt-enable register slice
// Notes on behaviour
// - register 0x41 holds limit bits 7:0, read/write, resets to 0x76
// - register 0x42 bits 1:0 hold limit bits 9:8; bits 7:2 unused; resets to 0x00
// - the joined ten-bit limit is unsigned and bounds offset both up and down
// - register 0x43 holds enable bits 7, 3 and 2, read/write, other bits read zero; resets to 0x00 (all masked)
// - enable bit 7 gates events of reference input three
// - enable bit 3 gates events of reference input two
// - enable bit 2 gates events of reference input one
package dplim_pkg;

    // register access port widths
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 8;

    // pull-in limit layout
    localparam int LIMIT_W    = 10;
    localparam int LIMIT_LO_W = 8;
    localparam int LIMIT_HI_W = LIMIT_W - LIMIT_LO_W;

    // register offsets on the configuration port
    localparam logic [ADDR_W-1:0] ADDR_LIMIT_LO  = 8'h41;
    localparam logic [ADDR_W-1:0] ADDR_LIMIT_HI  = 8'h42;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_EN_LO = 8'h43;

    // reset values
    localparam logic [LIMIT_LO_W-1:0] RST_LIMIT_LO  = 8'h76;
    localparam logic [LIMIT_HI_W-1:0] RST_LIMIT_HI  = 2'h0;
    localparam logic [DATA_W-1:0]     RST_IRQ_EN_LO = 8'h00;

    // read answer for an unmapped offset and for unused bits
    localparam logic [DATA_W-1:0]     RDATA_ZERO    = 8'h00;

    // reference inputs and their enable bit positions (one, two, three)
    localparam int NUM_REFS = 3;
    localparam int MASK_POS_REF_ONE   = 2;
    localparam int MASK_POS_REF_TWO   = 3;
    localparam int MASK_POS_REF_THREE = 7;
    localparam int MASK_POS [NUM_REFS] = '{MASK_POS_REF_ONE, MASK_POS_REF_TWO,
                                            MASK_POS_REF_THREE};

    // loops served by the clamp: main and auxiliary
    localparam int NUM_LOOPS = 2;
    localparam int LOOP_MAIN = 0;
    localparam int LOOP_AUX  = 1;

endpackage : dplim_pkg

// ==== verilog/dplim_regs.sv ====
// pull-in limit and reference interrupt-enable registers with loop offset clamps
`timescale 1ns/1ps
`default_nettype none
module dplim_regs #(
    parameter int OFS_W = 24                                       // loop offset width
) (
    input  wire logic                               clk,           // system clock, 20 MHz
    input  wire logic                               reset,         // synchronous, active high
    // register access from the serial configuration port
    input  wire logic                               reg_wr,        // write strobe, one cycle
    input  wire logic                               reg_rd,        // read strobe, one cycle
    input  wire logic [dplim_pkg::ADDR_W-1:0]       reg_addr,      // register offset
    input  wire logic [dplim_pkg::DATA_W-1:0]       reg_wdata,     // write byte
    output logic [dplim_pkg::DATA_W-1:0]            reg_rdata,     // read byte, registered
    output logic                                    reg_rvalid,    // read answer pulse
    // reference input events and their gated interrupt requests
    input  wire logic [dplim_pkg::NUM_REFS-1:0]     ref_event,     // events: one, two, three
    output logic [dplim_pkg::NUM_REFS-1:0]          ref_irq,       // unmasked events, registered
    // loop offsets
    input  wire logic signed [OFS_W-1:0]            main_ofs_in,   // main loop raw offset
    input  wire logic signed [OFS_W-1:0]            aux_ofs_in,    // aux loop raw offset
    input  wire logic signed [OFS_W-1:0]            cal_corr,      // oscillator calibration
    output logic signed [OFS_W-1:0]                 main_ofs_out,  // main loop clamped offset
    output logic signed [OFS_W-1:0]                 aux_ofs_out,   // aux loop clamped offset
    output logic                                    main_clipped,  // main loop at limit
    output logic                                    aux_clipped,   // aux loop at limit
    output logic [dplim_pkg::LIMIT_W-1:0]           pull_in_limit_value // joined limit
);

    // all state of the slice
    // lim_lo and lim_hi hold the two limit parts; only live bits of the high byte are kept
    // irq_en keeps the three live enable bits in input order, not in byte order
    // rdata and rvalid are the read answer; irq is the gated event stage
    typedef struct packed {
        logic [dplim_pkg::LIMIT_LO_W-1:0] lim_lo;
        logic [dplim_pkg::LIMIT_HI_W-1:0] lim_hi;
        logic [dplim_pkg::NUM_REFS-1:0]   irq_en;
        logic [dplim_pkg::DATA_W-1:0]     rdata;
        logic                             rvalid;
        logic [dplim_pkg::NUM_REFS-1:0]   irq;
    } dplim_regs_st_t;

    // st_r is the only storage; st_nxt is its next value
    dplim_regs_st_t st_r;
    dplim_regs_st_t st_nxt;

    // decode and gating helpers, all combinational
    logic [dplim_pkg::DATA_W-1:0]     irq_en_rb;      // enable byte as read back
    logic [dplim_pkg::NUM_REFS-1:0]   irq_en_wr;      // enable bits picked from write byte
    logic [dplim_pkg::NUM_REFS-1:0]   irq_gated;      // events that pass their enable
    logic [dplim_pkg::DATA_W-1:0]     rd_mux;         // read data before the register
    logic [dplim_pkg::LIMIT_W-1:0]    limit;          // joined limit feeding the clamps

    // loop views indexed by loop number, so the clamps come from one generate loop
    logic signed [OFS_W-1:0]          loop_in   [dplim_pkg::NUM_LOOPS];
    logic signed [OFS_W-1:0]          loop_out  [dplim_pkg::NUM_LOOPS];
    logic [dplim_pkg::NUM_LOOPS-1:0]  loop_clip;

    // elaboration checks: refuse a setup that the decode and the clamps cannot serve
    if (OFS_W < dplim_pkg::LIMIT_W + 2) begin : g_bad_ofs_w
        // the clamp needs room for the limit, a sign bit and a guard bit
        $error("dplim_regs: OFS_W too small for the pull-in limit");
    end
    if (dplim_pkg::LIMIT_LO_W != dplim_pkg::DATA_W) begin : g_bad_lo_w
        // the low limit part is written whole, so it must fill the data byte
        $error("dplim_regs: low limit part must match the data width");
    end
    if (dplim_pkg::LIMIT_HI_W < 1 ||
        dplim_pkg::LIMIT_HI_W > dplim_pkg::DATA_W) begin : g_bad_hi_w
        // the high limit part rides in the low bits of a single byte
        $error("dplim_regs: high limit part must fit one data byte");
    end
    if (dplim_pkg::NUM_LOOPS != 2) begin : g_bad_loops
        // only a main and an auxiliary loop have ports on this slice
        $error("dplim_regs: exactly two loops are served");
    end
    if (dplim_pkg::ADDR_LIMIT_LO == dplim_pkg::ADDR_LIMIT_HI ||
        dplim_pkg::ADDR_LIMIT_HI == dplim_pkg::ADDR_IRQ_EN_LO ||
        dplim_pkg::ADDR_LIMIT_LO == dplim_pkg::ADDR_IRQ_EN_LO) begin : g_bad_addr
        // overlapping offsets would make two case items collide in the decode
        $error("dplim_regs: register offsets must be distinct");
    end

    // the high byte only contributes its low bits; the unused top bits are zero
    // a two-byte update shows one mixed value between the writes, as the parts
    // are not latched together; the clamps follow that value for its span
    assign limit = {st_r.lim_hi, st_r.lim_lo};

    // per reference input: enable bit position, write pick-off and event gating
    // events are taken as already on this clock; a pin source needs its own synchroniser
    for (genvar i = 0; i < dplim_pkg::NUM_REFS; i++) begin : g_ref
        assign irq_en_wr[i] = reg_wdata[dplim_pkg::MASK_POS[i]];
        assign irq_gated[i] = ref_event[i] & st_r.irq_en[i];

        // a position past the byte could never be written or read back
        if (dplim_pkg::MASK_POS[i] >= dplim_pkg::DATA_W) begin : g_bad_pos
            $error("dplim_regs: enable bit position outside the data byte");
        end
        // two inputs on one bit would share a single enable
        for (genvar m = 0; m < i; m++) begin : g_pos_pair
            if (dplim_pkg::MASK_POS[m] == dplim_pkg::MASK_POS[i]) begin : g_bad_pair
                $error("dplim_regs: two inputs share one enable bit");
            end
        end
    end

    // readback of the enable byte; unused positions read as zero
    always_comb begin
        irq_en_rb = dplim_pkg::RDATA_ZERO;
        for (int k = 0; k < dplim_pkg::NUM_REFS; k++) begin
            irq_en_rb[dplim_pkg::MASK_POS[k]] = st_r.irq_en[k];
        end
    end

    // read decode; an unmapped offset answers zero rather than stalling the port
    // the address is decoded live, so it need only stand during the strobe cycle
    always_comb begin
        case (reg_addr)
            dplim_pkg::ADDR_LIMIT_LO: begin
                rd_mux = st_r.lim_lo;
            end
            dplim_pkg::ADDR_LIMIT_HI: begin
                rd_mux = {{(dplim_pkg::DATA_W-dplim_pkg::LIMIT_HI_W){1'b0}},
                          st_r.lim_hi};
            end
            dplim_pkg::ADDR_IRQ_EN_LO: begin
                rd_mux = irq_en_rb;
            end
            default: begin
                // an unmapped read still answers, so a polling host never waits
                rd_mux = dplim_pkg::RDATA_ZERO;
            end
        endcase
    end

    // next state: writes, read capture, interrupt gating, reset
    // writes to unused bits are dropped here, which is why readback shows zero there
    always_comb begin
        // hold by default; the answer pulse and the event stage refresh every cycle
        st_nxt        = st_r;
        st_nxt.rvalid = 1'b0;
        st_nxt.irq    = irq_gated;
        // each offset owns its own bits; a stray offset changes nothing
        if (reg_wr) begin
            case (reg_addr)
                dplim_pkg::ADDR_LIMIT_LO: begin
                    st_nxt.lim_lo = reg_wdata;
                end
                dplim_pkg::ADDR_LIMIT_HI: begin
                    st_nxt.lim_hi = reg_wdata[dplim_pkg::LIMIT_HI_W-1:0];
                end
                dplim_pkg::ADDR_IRQ_EN_LO: begin
                    st_nxt.irq_en = irq_en_wr;
                end
                default: begin
                    // unmapped offsets are ignored
                end
            endcase
        end
        // a read in the same cycle as a write returns the value before the write
        if (reg_rd) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata  = rd_mux;
        end
        // reset comes last, so it wins over a write or a read in the same cycle
        if (reset) begin
            st_nxt.lim_lo = dplim_pkg::RST_LIMIT_LO;
            st_nxt.lim_hi = dplim_pkg::RST_LIMIT_HI;
            for (int k = 0; k < dplim_pkg::NUM_REFS; k++) begin
                st_nxt.irq_en[k] = dplim_pkg::RST_IRQ_EN_LO[dplim_pkg::MASK_POS[k]];
            end
            // the read answer is dropped too, so no stale pulse leaks out of reset
            st_nxt.rdata  = dplim_pkg::RDATA_ZERO;
            st_nxt.rvalid = 1'b0;
            st_nxt.irq    = '0;
        end
    end

    // state register
    // reset is folded into st_nxt, so this process stays a plain copy
    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    // both loops see the same limit and calibration term
    assign loop_in[dplim_pkg::LOOP_MAIN] = main_ofs_in;
    assign loop_in[dplim_pkg::LOOP_AUX]  = aux_ofs_in;

    // one clamp per loop; both take the same limit, so a limit write moves both
    // loops on the same edge, one cycle after the write is taken
    for (genvar j = 0; j < dplim_pkg::NUM_LOOPS; j++) begin : g_loop
        dplim_clamp #(
            .OFS_W    (OFS_W)
        ) u_clamp (
            .clk      (clk),
            .reset    (reset),
            .ofs_in   (loop_in[j]),
            .cal_corr (cal_corr),
            .limit    (limit),
            .ofs_out  (loop_out[j]),
            .clipped  (loop_clip[j])
        );
    end

    // register port answers
    assign reg_rdata           = st_r.rdata;
    assign reg_rvalid          = st_r.rvalid;

    // gated interrupt requests
    assign ref_irq             = st_r.irq;

    // clamped loop offsets and their limit flags
    assign main_ofs_out        = loop_out[dplim_pkg::LOOP_MAIN];
    assign aux_ofs_out         = loop_out[dplim_pkg::LOOP_AUX];
    assign main_clipped        = loop_clip[dplim_pkg::LOOP_MAIN];
    assign aux_clipped         = loop_clip[dplim_pkg::LOOP_AUX];

    // joined limit, as the clamps see it
    assign pull_in_limit_value = limit;

endmodule // dplim_regs
`default_nettype wire
